// File: rtl/sdpr_host.sv
// Operation
// - Power register at 0010, bits 17:2 zero
// - Bit 1 zero powers IF loop down
// - Bit 0 zero powers RF loop down
// - Any loop on powers reference amplifier
// - 0011 holds 18-bit RF1 feedback count
// - 0100 holds 17-bit RF2 count, bit17 zero
// - 0101 holds 16-bit IF count, 17:16 zero
// - 0110 holds 13-bit RF1 reference count
// - Host keeps RF1 reference within gain bounds
// - 0111 holds 13-bit RF2 reference count
// - Host keeps RF2 reference within gain bounds
// - 1000 holds 13-bit IF reference count
// - Host keeps IF reference within RF1 bounds
// - Auto power bit forces both loops on
// - Host never writes addresses 9 to 15
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module sdpr_host #(
  parameter int HALF_DIV = sdpr_pkg::HALF_DIV
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  sdpr_link_if.host        link
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_END   = 3'b100
  } sdpr_state_t;

  sdpr_state_t                  state_reg;
  logic [7:0]                   wr_addr_reg;
  logic                         wr_pend_reg;
  logic [17:0]                  data_reg;
  logic [3:0]                   gain_reg;
  logic                         refused_reg;
  logic                         sent_reg;
  logic [sdpr_pkg::FRAME_W-1:0] frame_reg;
  logic [4:0]                   bit_reg;
  logic [7:0]                   div_reg;
  logic                         sclk_reg;
  logic                         ena_n_reg;
  logic                         hready_reg;
  logic [31:0]                  hrdata_reg;
  logic                         go;
  logic                         go_ok;
  logic [3:0]                   go_addr;
  logic [17:0]                  go_data;
  logic                         tick;

  function automatic logic [17:0] field_mask(input logic [3:0] a);
    unique case (a)
      sdpr_pkg::A_MAIN:    field_mask = sdpr_pkg::M_MAIN;
      sdpr_pkg::A_GAIN:    field_mask = sdpr_pkg::M_GAIN;
      sdpr_pkg::A_POWER:   field_mask = sdpr_pkg::M_POWER;
      sdpr_pkg::A_RF1_FB:  field_mask = sdpr_pkg::M_RF1_FB;
      sdpr_pkg::A_RF2_FB:  field_mask = sdpr_pkg::M_RF2_FB;
      sdpr_pkg::A_IF_FB:   field_mask = sdpr_pkg::M_IF_FB;
      default:             field_mask = sdpr_pkg::M_REF;
    endcase
  endfunction : field_mask

  function automatic logic [12:0] ref_min(input logic [1:0] kp);
    unique case (kp)
      2'b00:   ref_min = sdpr_pkg::REF_MIN_KP0;
      2'b01:   ref_min = sdpr_pkg::REF_MIN_KP1;
      2'b10:   ref_min = sdpr_pkg::REF_MIN_KP2;
      default: ref_min = sdpr_pkg::REF_MIN_KP3;
    endcase
  endfunction : ref_min

  function automatic logic ref_ok(input logic [17:0] d, input logic [1:0] kp);
    ref_ok = d[12:0] >= ref_min(kp) && d[12:0] <= sdpr_pkg::REF_MAX;
  endfunction : ref_ok

  // Zero-wait slave: address phase latched, write acts in data phase
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
      hready_reg  <= 1'b0;
    end else begin
      hready_reg  <= 1'b1;
      wr_pend_reg <= HSEL && HTRANS[1] && HREADY && HWRITE;
      wr_addr_reg <= HADDR[7:0];
      if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
        unique case (HADDR[7:0])
          sdpr_pkg::O_CMD_DATA:    hrdata_reg <= {14'h0000, data_reg};
          sdpr_pkg::O_STATUS:      hrdata_reg <= {29'h0000_0000, sent_reg, refused_reg,
                                                  state_reg != ST_IDLE};
          sdpr_pkg::O_GAIN_SHADOW: hrdata_reg <= {28'h000_0000, gain_reg};
          default:                 hrdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign go      = wr_pend_reg && wr_addr_reg == sdpr_pkg::O_CMD_GO;
  assign go_addr = HWDATA[3:0];
  assign go_data = data_reg & field_mask(go_addr);

  always_comb begin
    go_ok = state_reg == ST_IDLE && go_addr <= sdpr_pkg::A_IF_REF;
    unique case (go_addr)
      sdpr_pkg::A_RF1_REF: go_ok = go_ok && ref_ok(go_data, gain_reg[1:0]);
      sdpr_pkg::A_RF2_REF: go_ok = go_ok && ref_ok(go_data, gain_reg[3:2]);
      sdpr_pkg::A_IF_REF:  go_ok = go_ok && ref_ok(go_data, gain_reg[1:0]);
      default:             go_ok = go_ok;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      data_reg    <= 18'h0_0000;
      gain_reg    <= 4'h0;
      refused_reg <= 1'b0;
      sent_reg    <= 1'b0;
    end else begin
      if (wr_pend_reg && wr_addr_reg == sdpr_pkg::O_CMD_DATA) begin
        data_reg <= HWDATA[17:0];
      end
      if (go && go_ok && go_addr == sdpr_pkg::A_GAIN) begin
        gain_reg <= go_data[3:0];
      end
      // Set wins over a write-one clear in the same cycle
      if (wr_pend_reg && wr_addr_reg == sdpr_pkg::O_STATUS) begin
        refused_reg <= refused_reg & ~HWDATA[sdpr_pkg::S_REFUSED];
        sent_reg    <= sent_reg & ~HWDATA[sdpr_pkg::S_SENT];
      end
      if (go && !go_ok) begin
        refused_reg <= 1'b1;
      end
      if (state_reg == ST_END && tick) begin
        sent_reg <= 1'b1;
      end
    end
  end

  assign tick = div_reg == 8'(HALF_DIV - 1);

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      div_reg <= 8'h00;
    end else if (state_reg == ST_IDLE || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Data changes only while the link clock is low; device samples on rise
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
      sclk_reg  <= 1'b0;
      ena_n_reg <= 1'b1;
      frame_reg <= '0;
      bit_reg   <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go && go_ok) begin
            frame_reg <= {go_data, go_addr};
            ena_n_reg <= 1'b0;
            bit_reg   <= 5'h00;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sclk_reg <= !sclk_reg;
            if (sclk_reg) begin
              if (bit_reg == sdpr_pkg::LAST_BIT) begin
                state_reg <= ST_END;
              end else begin
                bit_reg   <= bit_reg + 5'h01;
                frame_reg <= {frame_reg[sdpr_pkg::FRAME_W-2:0], 1'b0};
              end
            end
          end
        end
        ST_END: begin
          if (tick) begin
            ena_n_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.serial_clock         = sclk_reg;
  assign link.serial_port_enable_n = ena_n_reg;
  assign link.serial_write_data    = frame_reg[sdpr_pkg::FRAME_W-1];
  assign HRDATA                    = hrdata_reg;
  assign HREADYOUT                 = hready_reg;
  assign HRESP                     = 1'b0;

endmodule : sdpr_host

// File: rtl/sdpr_pkg.sv
package sdpr_pkg;
  // Serial frame: 18 data bits first, then 4 address bits, msb first
  localparam int          DATA_W       = 18;
  localparam int          ADDR_W       = 4;
  localparam int          FRAME_W      = DATA_W + ADDR_W;
  localparam int          NUM_REGS     = 9;
  localparam logic [4:0]  LAST_BIT     = 5'h15;

  localparam logic [3:0]  A_MAIN       = 4'h0;
  localparam logic [3:0]  A_GAIN       = 4'h1;
  localparam logic [3:0]  A_POWER      = 4'h2;
  localparam logic [3:0]  A_RF1_FB     = 4'h3;
  localparam logic [3:0]  A_RF2_FB     = 4'h4;
  localparam logic [3:0]  A_IF_FB      = 4'h5;
  localparam logic [3:0]  A_RF1_REF    = 4'h6;
  localparam logic [3:0]  A_RF2_REF    = 4'h7;
  localparam logic [3:0]  A_IF_REF     = 4'h8;

  // Writable field of each register; everything else goes out as zero
  localparam logic [17:0] M_MAIN       = 18'h0_3C2C;
  localparam logic [17:0] M_GAIN       = 18'h0_003F;
  localparam logic [17:0] M_POWER      = 18'h0_0003;
  localparam logic [17:0] M_RF1_FB     = 18'h3_FFFF;
  localparam logic [17:0] M_RF2_FB     = 18'h1_FFFF;
  localparam logic [17:0] M_IF_FB      = 18'h0_FFFF;
  localparam logic [17:0] M_REF        = 18'h0_1FFF;

  localparam int          B_AUTO_ALL   = 3;
  localparam int          B_IF_ON      = 1;
  localparam int          B_RF_ON      = 0;
  localparam int          B_KP1        = 0;
  localparam int          B_KP2        = 2;
  localparam int          REF_W        = 13;
  localparam logic [17:0] WORD_RESET   = 18'h0_0000;

  localparam logic [12:0] REF_MAX      = 13'h1_FFD;
  localparam logic [12:0] REF_MIN_KP0  = 13'h0_007;
  localparam logic [12:0] REF_MIN_KP1  = 13'h0_008;
  localparam logic [12:0] REF_MIN_KP2  = 13'h0_00A;
  localparam logic [12:0] REF_MIN_KP3  = 13'h0_00E;

  // Controller register map, byte addresses on the bus
  localparam logic [7:0]  O_CMD_DATA   = 8'h00;
  localparam logic [7:0]  O_CMD_GO     = 8'h04;
  localparam logic [7:0]  O_STATUS     = 8'h08;
  localparam logic [7:0]  O_GAIN_SHADOW = 8'h0C;
  localparam int          S_BUSY       = 0;
  localparam int          S_REFUSED    = 1;
  localparam int          S_SENT       = 2;

  localparam int          MCLK_HZ      = 10_000_000;
  localparam int          SCLK_HZ      = 1_250_000;
  localparam int          HALF_DIV     = MCLK_HZ / (2 * SCLK_HZ);
endpackage : sdpr_pkg

// File: rtl/sdpr_link_if.sv
`timescale 1ns/10ps
interface sdpr_link_if;
  logic serial_clock;
  logic serial_port_enable_n;
  logic serial_write_data;

  modport host (
    output serial_clock,
    output serial_port_enable_n,
    output serial_write_data
  );

  modport device (
    input serial_clock,
    input serial_port_enable_n,
    input serial_write_data
  );
endinterface : sdpr_link_if

// File: rtl/sdpr_device.sv
`timescale 1ns/10ps
module sdpr_device (
  sdpr_link_if.device      link,
  input  wire logic        POR_N,
  output logic             IF_LOOP_POWER_ON,
  output logic             RF_LOOP_POWER_ON,
  output logic             REF_AMP_ON,
  output logic             AUTO_POWER_ALL,
  output logic [1:0]       RF1_DETECTOR_GAIN_CODE,
  output logic [1:0]       RF2_DETECTOR_GAIN_CODE,
  output logic [17:0]      RF1_FEEDBACK_COUNT,
  output logic [16:0]      RF2_FEEDBACK_COUNT,
  output logic [15:0]      IF_FEEDBACK_COUNT,
  output logic [12:0]      RF1_REFERENCE_COUNT,
  output logic [12:0]      RF2_REFERENCE_COUNT,
  output logic [12:0]      IF_REFERENCE_COUNT
);

  logic [4:0]                    bit_count_reg;
  logic [sdpr_pkg::FRAME_W-2:0]  shift_reg;
  logic [sdpr_pkg::FRAME_W-1:0]  frame;
  logic                          commit;
  logic [3:0]                    commit_addr;
  logic [17:0]                   commit_data;
  logic [17:0]                   word_reg [sdpr_pkg::NUM_REGS];
  logic [17:0]                   main_next;
  logic [17:0]                   power_next;
  logic                          if_on_reg;
  logic                          rf_on_reg;
  logic                          ref_amp_reg;
  logic                          if_on_next;
  logic                          rf_on_next;

  // Counter is held clear by the frame's own enable, since the link
  // clock stops between frames and no edge would be left to clear it.
  always_ff @(posedge link.serial_clock or negedge POR_N
              or posedge link.serial_port_enable_n) begin
    if (!POR_N) begin
      bit_count_reg <= 5'h00;
    end else if (link.serial_port_enable_n) begin
      bit_count_reg <= 5'h00;
    end else if (bit_count_reg <= sdpr_pkg::LAST_BIT) begin
      bit_count_reg <= bit_count_reg + 5'h01;
    end
  end

  always_ff @(posedge link.serial_clock or negedge POR_N) begin
    if (!POR_N) begin
      shift_reg <= '0;
    end else if (!link.serial_port_enable_n) begin
      shift_reg <= {shift_reg[sdpr_pkg::FRAME_W-3:0], link.serial_write_data};
    end
  end

  // Last bit taken at the 22nd rising edge commits straight away;
  // bits beyond it are ignored until the enable rises.
  assign frame       = {shift_reg, link.serial_write_data};
  assign commit      = !link.serial_port_enable_n && (bit_count_reg == sdpr_pkg::LAST_BIT);
  assign commit_addr = frame[sdpr_pkg::ADDR_W-1:0];
  assign commit_data = frame[sdpr_pkg::FRAME_W-1:sdpr_pkg::ADDR_W];

  // Reserved addresses 9 to 15 match no slot and are dropped
  generate
    for (genvar i = 0; i < sdpr_pkg::NUM_REGS; i++) begin : g_word
      always_ff @(posedge link.serial_clock or negedge POR_N) begin
        if (!POR_N) begin
          word_reg[i] <= sdpr_pkg::WORD_RESET;
        end else if (commit && commit_addr == 4'(i)) begin
          word_reg[i] <= commit_data;
        end
      end
    end
  endgenerate

  always_comb begin
    main_next  = word_reg[sdpr_pkg::A_MAIN];
    power_next = word_reg[sdpr_pkg::A_POWER];
    if (commit && commit_addr == sdpr_pkg::A_MAIN) begin
      main_next = commit_data;
    end
    if (commit && commit_addr == sdpr_pkg::A_POWER) begin
      power_next = commit_data;
    end
    if_on_next = power_next[sdpr_pkg::B_IF_ON]
               | main_next[sdpr_pkg::B_AUTO_ALL];
    rf_on_next = power_next[sdpr_pkg::B_RF_ON]
               | main_next[sdpr_pkg::B_AUTO_ALL];
  end

  // Effective enables kept in their own flops so the analog side
  // sees glitch-free levels that change only at a commit.
  always_ff @(posedge link.serial_clock or negedge POR_N) begin
    if (!POR_N) begin
      if_on_reg   <= 1'b0;
      rf_on_reg   <= 1'b0;
      ref_amp_reg <= 1'b0;
    end else if (commit) begin
      if_on_reg   <= if_on_next;
      rf_on_reg   <= rf_on_next;
      ref_amp_reg <= if_on_next | rf_on_next;
    end
  end

  assign IF_LOOP_POWER_ON       = if_on_reg;
  assign RF_LOOP_POWER_ON       = rf_on_reg;
  assign REF_AMP_ON             = ref_amp_reg;
  assign AUTO_POWER_ALL         = word_reg[sdpr_pkg::A_MAIN][sdpr_pkg::B_AUTO_ALL];
  assign RF1_DETECTOR_GAIN_CODE = word_reg[sdpr_pkg::A_GAIN][sdpr_pkg::B_KP1 +: 2];
  assign RF2_DETECTOR_GAIN_CODE = word_reg[sdpr_pkg::A_GAIN][sdpr_pkg::B_KP2 +: 2];
  assign RF1_FEEDBACK_COUNT     = word_reg[sdpr_pkg::A_RF1_FB];
  assign RF2_FEEDBACK_COUNT     = word_reg[sdpr_pkg::A_RF2_FB][16:0];
  assign IF_FEEDBACK_COUNT      = word_reg[sdpr_pkg::A_IF_FB][15:0];
  assign RF1_REFERENCE_COUNT    = word_reg[sdpr_pkg::A_RF1_REF][12:0];
  assign RF2_REFERENCE_COUNT    = word_reg[sdpr_pkg::A_RF2_REF][12:0];
  assign IF_REFERENCE_COUNT     = word_reg[sdpr_pkg::A_IF_REF][12:0];

endmodule : sdpr_device

// File: tb/sdpr_monitor.sv
`timescale 1ns/10ps
module sdpr_monitor (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic serial_clock,
  input wire logic serial_port_enable_n,
  input wire logic serial_write_data,
  input wire logic IF_LOOP_POWER_ON,
  input wire logic RF_LOOP_POWER_ON,
  input wire logic REF_AMP_ON,
  input wire logic AUTO_POWER_ALL
);
  logic       clk_q;
  logic [4:0] rise_cnt;

  always_ff @(posedge MCLK) begin
    clk_q <= serial_clock;
  end

  // Counts link rises per frame, cleared whenever the frame is closed
  always_ff @(posedge MCLK) begin
    if (!RESETN || serial_port_enable_n) begin
      rise_cnt <= 5'h00;
    end else if (serial_clock && !clk_q) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  // Half period fixed at four MCLK, as the bench sets the divider
  sequence half_high;
    serial_clock [*4] ##1 !serial_clock;
  endsequence

  sequence quiet_start;
    !serial_clock [*3];
  endsequence

  a_clk_idle_low: assert property (serial_port_enable_n |-> !serial_clock)
    else $error("link clock high outside a frame");
  a_start_quiet: assert property ($fell(serial_port_enable_n) |-> quiet_start)
    else $error("link clock moved too soon after frame start");
  a_half_period: assert property ($rose(serial_clock) |-> half_high)
    else $error("link clock high phase not four cycles");
  a_data_steady: assert property ($rose(serial_clock) |-> $stable(serial_write_data))
    else $error("link data changed at a rising link clock");
  a_frame_len: assert property ($rose(serial_port_enable_n) |-> rise_cnt == 5'h16)
    else $error("frame did not carry 22 bits");
  a_end_quiet: assert property ($rose(serial_port_enable_n) |-> !$past(serial_clock, 3))
    else $error("frame closed too soon after last bit");
  a_ref_amp_or: assert property (REF_AMP_ON == (IF_LOOP_POWER_ON | RF_LOOP_POWER_ON))
    else $error("reference amplifier does not follow loop enables");
  a_auto_both: assert property (AUTO_POWER_ALL |-> IF_LOOP_POWER_ON && RF_LOOP_POWER_ON)
    else $error("auto power did not force both loops on");
endmodule : sdpr_monitor

// File: tb/sdpr_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module sdpr_test;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        por_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        if_on;
  logic        rf_on;
  logic        amp_on;
  logic        auto_all;
  logic [1:0]  kp1;
  logic [1:0]  kp2;
  logic        hresp;
  logic [17:0] rf1_fb;
  logic [16:0] rf2_fb;
  logic [15:0] n_if;
  logic [12:0] rf1_ref;
  logic [12:0] rf2_ref;
  logic [12:0] r_if;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          check_count = 0;

  always #50 mclk = ~mclk;

  sdpr_link_if sdpr_link_if_inst ();
  sdpr_host #(.HALF_DIV(4)) sdpr_host_inst (.MCLK(mclk), .RESETN(resetn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .link(sdpr_link_if_inst.host));
  sdpr_device sdpr_device_inst (.link(sdpr_link_if_inst.device), .POR_N(por_n),
    .IF_LOOP_POWER_ON(if_on), .RF_LOOP_POWER_ON(rf_on), .REF_AMP_ON(amp_on),
    .AUTO_POWER_ALL(auto_all), .RF1_DETECTOR_GAIN_CODE(kp1), .RF2_DETECTOR_GAIN_CODE(kp2),
    .RF1_FEEDBACK_COUNT(rf1_fb), .RF2_FEEDBACK_COUNT(rf2_fb), .IF_FEEDBACK_COUNT(n_if),
    .RF1_REFERENCE_COUNT(rf1_ref), .RF2_REFERENCE_COUNT(rf2_ref), .IF_REFERENCE_COUNT(r_if));
  sdpr_monitor sdpr_monitor_inst (.MCLK(mclk), .RESETN(resetn),
    .serial_clock(sdpr_link_if_inst.serial_clock),
    .serial_port_enable_n(sdpr_link_if_inst.serial_port_enable_n),
    .serial_write_data(sdpr_link_if_inst.serial_write_data),
    .IF_LOOP_POWER_ON(if_on), .RF_LOOP_POWER_ON(rf_on), .REF_AMP_ON(amp_on),
    .AUTO_POWER_ALL(auto_all));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Reads at the edge see pre-update flop values, which is the bus sample
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      error_cnt++;
      wrap_up();
    end
  endtask : ahb

  task automatic send(input logic [3:0] a, input logic [17:0] d, input logic refused);
    int n;
    n = 0;
    ahb(1'b1, sdpr_pkg::O_CMD_DATA, {14'h0000, d});
    ahb(1'b1, sdpr_pkg::O_CMD_GO, {28'h000_0000, a});
    do begin ahb(1'b0, sdpr_pkg::O_STATUS, 32'h0000_0000); n++; end
      while (rd[sdpr_pkg::S_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      wrap_up();
    end
    `CHK(rd[sdpr_pkg::S_REFUSED], refused)
    `CHK(rd[sdpr_pkg::S_SENT], ~refused)
    ahb(1'b1, sdpr_pkg::O_STATUS, 32'h0000_0006);
  endtask : send

  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    `CHK({if_on, rf_on, amp_on, rf1_fb}, 21'h00_0000)
    send(sdpr_pkg::A_POWER, 18'h3_FFFF, 1'b0);
    `CHK({if_on, rf_on, amp_on}, 3'h7)
    send(sdpr_pkg::A_POWER, 18'h0_0001, 1'b0);
    `CHK({if_on, rf_on, amp_on}, 3'h3)
    send(sdpr_pkg::A_POWER, 18'h0_0002, 1'b0);
    `CHK({if_on, rf_on, amp_on}, 3'h5)
    send(sdpr_pkg::A_POWER, 18'h0_0000, 1'b0);
    `CHK({if_on, rf_on, amp_on}, 3'h0)
    $display("test power done");
    send(sdpr_pkg::A_RF1_FB, 18'h3_FFFF, 1'b0);
    send(sdpr_pkg::A_RF2_FB, 18'h3_FFFF, 1'b0);
    send(sdpr_pkg::A_IF_FB, 18'h3_FFFF, 1'b0);
    `CHK(rf1_fb, 18'h3_FFFF)
    `CHK(rf2_fb, 17'h1_FFFF)
    `CHK(n_if, 16'hFFFF)
    send(sdpr_pkg::A_RF1_FB, 18'h2_AAAA, 1'b0);
    `CHK({rf1_fb, rf2_fb}, {18'h2_AAAA, 17'h1_FFFF})
    $display("test feedback done");
    send(sdpr_pkg::A_GAIN, 18'h0_000B, 1'b0);
    `CHK({kp2, kp1}, 4'hB)
    ahb(1'b0, sdpr_pkg::O_GAIN_SHADOW, 32'h0000_0000);
    `CHK(rd, 32'h0000_000B)
    send(sdpr_pkg::A_RF1_REF, 18'h0_000D, 1'b1);
    send(sdpr_pkg::A_RF1_REF, 18'h0_000E, 1'b0);
    `CHK(rf1_ref, 13'h0_00E)
    send(sdpr_pkg::A_IF_REF, 18'h0_000D, 1'b1);
    send(sdpr_pkg::A_RF2_REF, 18'h0_0009, 1'b1);
    send(sdpr_pkg::A_RF2_REF, 18'h0_000A, 1'b0);
    send(sdpr_pkg::A_IF_REF, 18'h0_1FFE, 1'b1);
    send(sdpr_pkg::A_IF_REF, 18'h0_1FFD, 1'b0);
    `CHK({rf2_ref, r_if}, {13'h0_00A, 13'h1_FFD})
    send(sdpr_pkg::A_GAIN, 18'h0_0004, 1'b0);
    send(sdpr_pkg::A_RF1_REF, 18'h0_0006, 1'b1);
    send(sdpr_pkg::A_RF1_REF, 18'h0_0007, 1'b0);
    send(sdpr_pkg::A_RF2_REF, 18'h0_0007, 1'b1);
    send(sdpr_pkg::A_RF2_REF, 18'h0_0008, 1'b0);
    `CHK({rf1_ref, rf2_ref, r_if}, {13'h0_007, 13'h0_008, 13'h1_FFD})
    $display("test reference done");
    send(4'h9, 18'h0_0001, 1'b1);
    send(4'hF, 18'h0_0001, 1'b1);
    `CHK({rf1_fb, if_on, rf_on}, {18'h2_AAAA, 2'h0})
    $display("test reserved done");
    send(sdpr_pkg::A_MAIN, 18'h0_0008, 1'b0);
    `CHK({auto_all, if_on, rf_on, amp_on}, 4'hF)
    send(sdpr_pkg::A_MAIN, 18'h0_0000, 1'b0);
    `CHK({auto_all, if_on, rf_on, amp_on}, 4'h0)
    $display("test auto done");
    ahb(1'b1, 8'h14, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    ahb(1'b0, sdpr_pkg::O_CMD_DATA, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    // Second go while a frame is in flight is refused, first frame unharmed
    ahb(1'b1, sdpr_pkg::O_CMD_DATA, 32'h0001_5555);
    ahb(1'b1, sdpr_pkg::O_CMD_GO, {28'h000_0000, sdpr_pkg::A_RF1_FB});
    ahb(1'b1, sdpr_pkg::O_CMD_DATA, 32'h0000_0001);
    ahb(1'b1, sdpr_pkg::O_CMD_GO, {28'h000_0000, sdpr_pkg::A_RF2_FB});
    ahb(1'b0, sdpr_pkg::O_STATUS, 32'h0000_0000);
    `CHK(rd[2:0], 3'h3)
    for (int i = 0; i < 400 && rd[sdpr_pkg::S_BUSY] !== 1'b0; i++) begin
      ahb(1'b0, sdpr_pkg::O_STATUS, 32'h0000_0000);
    end
    if (rd[sdpr_pkg::S_BUSY] !== 1'b0) begin
      error_cnt++;
      wrap_up();
    end
    `CHK(rd[2:0], 3'h6)
    `CHK({rf1_fb, rf2_fb}, {18'h1_5555, 17'h1_FFFF})
    ahb(1'b1, sdpr_pkg::O_STATUS, 32'h0000_0006);
    $display("test bus done");
    wrap_up();
  end
endmodule : sdpr_test
